// ---- hdl/pric_ctrl.sv ----
// Prioritised interrupt controller with Avalon-MM register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "pric_defs.svh"

// Functional notes
// - Core level masks user sources at or below it; level 7 blocks all.
// - Trap sources sit at levels 11 to 14 and are never masked.
// - Timed disable suppresses user priorities 1 to 6 while its count runs.
// - Priority 7 user sources still interrupt during timed disable.
// - Timed disable never gates traps.
// - Equal priorities: lowest vector number wins.
// - Status word: digit carry bit 8, level bits 7:5, repeat bit 4, flags 3:0.
// - Trap control: nesting disable bit 15, trap flags bits 4 down to 1.
// - Table control: alternate table bit 15, timed-disable active 14, edge selects 4:0.
// - Pending flags, sixteen per register; eighth register uses bits 5:0.
// - Enable bits mirror pending layout.
// - Priority registers: four 3-bit fields at 14:12, 10:8, 6:4, 2:0.
// - Priority 111 is level 7; 000 disables the source.
// - Reset assigns every user source priority 4.
// - Nesting disable stops a new user request preempting one in service.
module pric_ctrl import pric_pkg::*; #(
	parameter int N_SRC = 118,
	parameter int TDIS_W = 14
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	// Avalon-MM slave
	input wire logic [9:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Peripheral and trap events
	input wire logic [N_SRC-1:0] IRQ_I,
	input wire logic TRAP_MATH_I,
	input wire logic TRAP_ADDR_I,
	input wire logic TRAP_STACK_I,
	input wire logic TRAP_CLKFAIL_I,
	// Core side
	input wire logic CORE_ACK_I,
	input wire logic CORE_RET_I,
	output logic CORE_IRQ_O,
	output logic [6:0] CORE_VECTOR_O,
	output logic CORE_IS_TRAP_O,
	output logic [3:0] CORE_LEVEL_O,
	output logic CORE_ALT_TABLE_O,
	output logic [4:0] EXT_EDGE_SEL_O
);

	// ==========================================
	// Parameter checks
	if (N_SRC < 1 || N_SRC > 118) begin : g_bad_nsrc
		$error("N_SRC must lie in 1..118");
	end
	if (TDIS_W < 1 || TDIS_W > 16) begin : g_bad_tdis
		$error("TDIS_W must lie in 1..16");
	end

	// ==========================================
	// Bus slave
	logic wait_r;
	logic [31:0] rdata_r;
	logic [15:0] rmux;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic wr_go;
	logic req;
	logic hit_pend;
	logic hit_en;
	logic hit_prio;
	logic [2:0] grp_sel;
	logic [4:0] prio_sel;

	assign req = AVS_READ_I | AVS_WRITE_I;
	// A write lands only at the edge where waitrequest is sampled low
	assign wr_go = AVS_WRITE_I & ~wait_r;
	assign wdata = AVS_WRITEDATA_I[15:0];
	assign wmask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
	assign hit_pend = (AVS_ADDRESS_I[9:5] == 5'(`PRIC_PEND_BASE >> 5));
	assign hit_en = (AVS_ADDRESS_I[9:5] == 5'(`PRIC_ENABLE_BASE >> 5));
	assign hit_prio = (AVS_ADDRESS_I[9:7] == 3'(`PRIC_PRIO_BASE >> 7));
	assign grp_sel = AVS_ADDRESS_I[4:2];
	assign prio_sel = AVS_ADDRESS_I[6:2];

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~(req & wait_r);
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			rdata_r <= 32'h0000_0000;
		end else if (AVS_READ_I && wait_r) begin
			rdata_r <= {16'h0000, rmux};
		end
	end

	assign AVS_WAITREQUEST_O = wait_r;
	assign AVS_READDATA_O = rdata_r;

	// ==========================================
	// Core state registers
	logic [8:0] status_r;
	logic [1:0] cc_r;
	logic nest_dis_r;
	logic [4:1] trap_r;
	logic alt_r;
	logic [4:0] edge_r;
	logic [TDIS_W-1:0] tdis_r;
	logic in_service_r;
	pric_level_t saved_lvl_r;
	pric_level_t core_lvl;
	logic tdis_active;
	logic [4:1] trap_set;

	assign core_lvl = {cc_r[1], status_r[`PRIC_STATUS_LVL_HI:`PRIC_STATUS_LVL_LO]};
	assign tdis_active = (tdis_r != '0);
	assign trap_set = {TRAP_MATH_I, TRAP_ADDR_I, TRAP_STACK_I, TRAP_CLKFAIL_I};

	logic take;
	assign take = CORE_ACK_I & CORE_IRQ_O;

	// Status word; a taken request raises the level, a return restores it
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			status_r <= 9'h000;
		end else if (take) begin
			status_r[`PRIC_STATUS_LVL_HI:`PRIC_STATUS_LVL_LO] <= CORE_LEVEL_O[2:0];
		end else if (CORE_RET_I) begin
			status_r[`PRIC_STATUS_LVL_HI:`PRIC_STATUS_LVL_LO] <= saved_lvl_r[2:0];
		end else if (wr_go && AVS_ADDRESS_I == `PRIC_STATUS_OFS) begin
			status_r <= (status_r & ~wmask[8:0]) | (wdata[8:0] & wmask[8:0]);
		end
	end

	// Core control: level extension and program space view
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			cc_r <= 2'b00;
		end else if (take) begin
			cc_r[1] <= CORE_IS_TRAP_O;
		end else if (CORE_RET_I) begin
			cc_r[1] <= saved_lvl_r[3];
		end else if (wr_go && AVS_ADDRESS_I == `PRIC_CORE_CTRL_OFS && AVS_BYTEENABLE_I[0]) begin
			cc_r <= wdata[`PRIC_CC_LVL_EXT_BIT:`PRIC_CC_PSPACE_BIT];
		end
	end

	// One level of save is enough for the return path the core drives
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			saved_lvl_r <= 4'h0;
			in_service_r <= 1'b0;
		end else if (take) begin
			saved_lvl_r <= core_lvl;
			in_service_r <= 1'b1;
		end else if (CORE_RET_I) begin
			in_service_r <= 1'b0;
		end
	end

	// Trap flags: a hardware set beats a software clear in the same cycle
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			nest_dis_r <= 1'b0;
			trap_r <= 4'h0;
		end else begin
			trap_r <= trap_r | trap_set;
			if (wr_go && AVS_ADDRESS_I == `PRIC_TRAP_CTRL_OFS) begin
				if (AVS_BYTEENABLE_I[1]) begin
					nest_dis_r <= wdata[`PRIC_TC_NEST_DIS_BIT];
				end
				if (AVS_BYTEENABLE_I[0]) begin
					trap_r <= wdata[`PRIC_TC_MATH_BIT:`PRIC_TC_CLKFAIL_BIT] | trap_set;
				end
			end
		end
	end

	// Table select and edge selects; the active bit is read-only
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			alt_r <= 1'b0;
			edge_r <= 5'h00;
		end else if (wr_go && AVS_ADDRESS_I == `PRIC_TABLE_CTRL_OFS) begin
			if (AVS_BYTEENABLE_I[1]) begin
				alt_r <= wdata[`PRIC_EC_ALT_TABLE_BIT];
			end
			if (AVS_BYTEENABLE_I[0]) begin
				edge_r <= wdata[4:0];
			end
		end
	end

	// Timed disable: a write loads the cycle count, which then runs down
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			tdis_r <= '0;
		end else if (wr_go && AVS_ADDRESS_I == `PRIC_TDIS_COUNT_OFS) begin
			tdis_r <= wdata[TDIS_W-1:0];
		end else if (tdis_active) begin
			tdis_r <= tdis_r - 1'b1;
		end
	end

	// ==========================================
	// Per-source flags, enables and priorities
	logic [N_SRC-1:0] pend_r;
	logic [N_SRC-1:0] en_r;
	pric_prio_t [N_SRC-1:0] prio_r;
	logic [N_SRC-1:0] elig;

	for (genvar i = 0; i < N_SRC; i++) begin : g_src
		localparam logic [2:0] GRP = 3'(i / 16);
		localparam int BIT = i % 16;
		localparam logic [4:0] PGRP = 5'(i / 4);
		localparam int PBIT = (i % 4) * 4;

		always_ff @(posedge REF_CLK_I) begin
			if (!RSTN_I) begin
				pend_r[i] <= 1'b0;
			end else if (wr_go && hit_pend && grp_sel == GRP && wmask[BIT]) begin
				pend_r[i] <= wdata[BIT] | IRQ_I[i];
			end else if (IRQ_I[i]) begin
				pend_r[i] <= 1'b1;
			end
		end

		always_ff @(posedge REF_CLK_I) begin
			if (!RSTN_I) begin
				en_r[i] <= 1'b0;
			end else if (wr_go && hit_en && grp_sel == GRP && wmask[BIT]) begin
				en_r[i] <= wdata[BIT];
			end
		end

		always_ff @(posedge REF_CLK_I) begin
			if (!RSTN_I) begin
				prio_r[i] <= `PRIC_PRIO_RESET;
			end else if (wr_go && hit_prio && prio_sel == PGRP && wmask[PBIT]) begin
				prio_r[i] <= wdata[PBIT+2:PBIT];
			end
		end

		// A flag left pending keeps requesting until software clears it
		assign elig[i] = pend_r[i] & en_r[i]
			& (prio_r[i] != `PRIC_PRIO_OFF)
			& ({1'b0, prio_r[i]} > core_lvl)
			& ~(tdis_active & (prio_r[i] != `PRIC_PRIO_TOP))
			& ~(nest_dis_r & in_service_r);
	end

	// ==========================================
	// Read multiplexer
	logic [127:0] pend_pad;
	logic [127:0] en_pad;
	logic [511:0] prio_pad;

	always_comb begin
		pend_pad = 128'h0;
		en_pad = 128'h0;
		prio_pad = 512'h0;
		pend_pad[N_SRC-1:0] = pend_r;
		en_pad[N_SRC-1:0] = en_r;
		for (int k = 0; k < N_SRC; k++) begin
			prio_pad[k*4 +: 3] = prio_r[k];
		end
	end

	always_comb begin
		rmux = 16'h0000;
		if (hit_pend) begin
			rmux = pend_pad[{grp_sel, 4'h0} +: 16];
		end else if (hit_en) begin
			rmux = en_pad[{grp_sel, 4'h0} +: 16];
		end else if (hit_prio) begin
			rmux = prio_pad[{prio_sel, 4'h0} +: 16];
		end else begin
			unique case (AVS_ADDRESS_I)
				`PRIC_STATUS_OFS: rmux = {7'h00, status_r};
				`PRIC_CORE_CTRL_OFS: rmux = {12'h000, cc_r, 2'b00};
				`PRIC_TRAP_CTRL_OFS: rmux = {nest_dis_r, 10'h000, trap_r, 1'b0};
				`PRIC_TABLE_CTRL_OFS: rmux = {alt_r, tdis_active, 9'h000, edge_r};
				`PRIC_TDIS_COUNT_OFS: rmux = 16'(tdis_r);
				default: rmux = 16'h0000;
			endcase
		end
	end

	// ==========================================
	// Arbitration
	logic found;
	pric_prio_t best_prio;
	logic [6:0] best_idx;
	logic trap_req;
	logic [2:0] trap_vec;

	// Walk downward so an equal priority at a lower vector replaces the winner
	always_comb begin
		found = 1'b0;
		best_prio = 3'h0;
		best_idx = 7'h00;
		for (int j = N_SRC - 1; j >= 0; j--) begin
			if (elig[j] && (!found || prio_r[j] >= best_prio)) begin
				found = 1'b1;
				best_prio = prio_r[j];
				best_idx = 7'(j);
			end
		end
	end

	// Traps bypass core level and timed disable; lowest vector wins
	assign trap_req = |trap_r;
	always_comb begin
		trap_vec = 3'h0;
		for (int t = 4; t >= 1; t--) begin
			if (trap_r[t]) begin
				trap_vec = 3'(t);
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			CORE_IRQ_O <= 1'b0;
			CORE_VECTOR_O <= 7'h00;
			CORE_IS_TRAP_O <= 1'b0;
			CORE_LEVEL_O <= 4'h0;
		end else if (trap_req) begin
			CORE_IRQ_O <= 1'b1;
			CORE_VECTOR_O <= {4'h0, trap_vec};
			CORE_IS_TRAP_O <= 1'b1;
			CORE_LEVEL_O <= `PRIC_TRAP_TOP_LVL - {1'b0, trap_vec};
		end else begin
			CORE_IRQ_O <= found;
			CORE_VECTOR_O <= `PRIC_USER_VEC_BASE + best_idx;
			CORE_IS_TRAP_O <= 1'b0;
			CORE_LEVEL_O <= {1'b0, best_prio};
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			CORE_ALT_TABLE_O <= 1'b0;
			EXT_EDGE_SEL_O <= 5'h00;
		end else begin
			CORE_ALT_TABLE_O <= alt_r;
			EXT_EDGE_SEL_O <= edge_r;
		end
	end

endmodule
`default_nettype wire

// ---- hdl/pric_defs.svh ----
// Address map, field positions, reset values and trap levels of the interrupt controller
`ifndef PRIC_DEFS_SVH
`define PRIC_DEFS_SVH

// ==========================================
// Register byte offsets
`define PRIC_STATUS_OFS 10'h000
`define PRIC_CORE_CTRL_OFS 10'h004
`define PRIC_TRAP_CTRL_OFS 10'h008
`define PRIC_TABLE_CTRL_OFS 10'h00C
`define PRIC_TDIS_COUNT_OFS 10'h010
`define PRIC_PEND_BASE 10'h040
`define PRIC_ENABLE_BASE 10'h060
`define PRIC_PRIO_BASE 10'h080

// ==========================================
// Field positions
`define PRIC_STATUS_DCARRY_BIT 8
`define PRIC_STATUS_LVL_HI 7
`define PRIC_STATUS_LVL_LO 5
`define PRIC_CC_LVL_EXT_BIT 3
`define PRIC_CC_PSPACE_BIT 2
`define PRIC_TC_NEST_DIS_BIT 15
`define PRIC_TC_MATH_BIT 4
`define PRIC_TC_ADDR_BIT 3
`define PRIC_TC_STACK_BIT 2
`define PRIC_TC_CLKFAIL_BIT 1
`define PRIC_EC_ALT_TABLE_BIT 15
`define PRIC_EC_TDIS_ACTIVE_BIT 14

// ==========================================
// Values
`define PRIC_PRIO_RESET 3'h4
`define PRIC_PRIO_OFF 3'h0
`define PRIC_PRIO_TOP 3'h7
`define PRIC_TRAP_TOP_LVL 4'hF
`define PRIC_USER_VEC_BASE 7'h08

`endif

// ---- hdl/pric_pkg.sv ----
// Types shared by the interrupt controller
package pric_pkg;
	typedef logic [3:0] pric_level_t;
	typedef logic [2:0] pric_prio_t;
	typedef enum logic [1:0] {
		PRIC_BUS_IDLE = 2'b01,
		PRIC_BUS_ANSWER = 2'b10
	} pric_bus_state_t;
endpackage

// ---- verification/pric_core_model.sv ----
// Behavioural core that takes requests from the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module pric_core_model #(
	parameter int DLY = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Controller side
	input wire logic irq_i,
	output logic ack_o,
	output logic ret_o,
	// Bench control
	input wire logic go_i,
	input wire logic ret_req_i
);
	int wait_r;
	logic busy_r;
	// ====
	// Take a request after DLY cycles, then wait until it is withdrawn
	// Waiting avoids a second take of the same vector before the controller masks it
	always_ff @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (!rstn_i) begin
			wait_r <= 0;
			busy_r <= 1'b0;
		end else if (busy_r) begin
			busy_r <= irq_i;
		end else if (irq_i && go_i) begin
			wait_r <= wait_r + 1;
			if (wait_r >= DLY) begin
				ack_o <= 1'b1;
				busy_r <= 1'b1;
				wait_r <= 0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		ret_o <= rstn_i && ret_req_i;
	end
endmodule
`default_nettype wire

// ---- verification/pric_ctrl_sva.sv ----
// Assertions on the interrupt controller's ports
`timescale 1ns/100ps
`default_nettype none
module pric_ctrl_chk #(
	parameter int N_SRC = 118
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	// Bus and traps
	input wire logic AVS_WRITE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic TRAP_MATH_I,
	input wire logic TRAP_CLKFAIL_I,
	// Core side
	input wire logic CORE_ACK_I,
	input wire logic CORE_IRQ_O,
	input wire logic [6:0] CORE_VECTOR_O,
	input wire logic CORE_IS_TRAP_O,
	input wire logic [3:0] CORE_LEVEL_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	// ====
	// Bus and request checks
	AST_WAIT_ONE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("wait low too long");
	AST_USER_LVL: assert property (
		CORE_IRQ_O && !CORE_IS_TRAP_O |-> CORE_LEVEL_O inside {[4'h1:4'h7]}) else $error("user level");
	AST_USER_VEC: assert property (
		CORE_IRQ_O && !CORE_IS_TRAP_O |-> CORE_VECTOR_O >= 7'h08 && int'(CORE_VECTOR_O) < N_SRC + 8)
		else $error("user vector");
	AST_TRAP_LVL: assert property (
		CORE_IRQ_O && CORE_IS_TRAP_O |-> CORE_VECTOR_O inside {[7'h01:7'h04]}
		&& CORE_LEVEL_O == 4'hF - CORE_VECTOR_O[3:0]) else $error("trap level");
	AST_CLKFAIL: assert property (
		TRAP_CLKFAIL_I |-> ##[1:2] (CORE_IRQ_O && CORE_IS_TRAP_O && CORE_VECTOR_O == 7'h01))
		else $error("trap masked");
	AST_MATH: assert property (
		TRAP_MATH_I |-> ##[1:2] (CORE_IRQ_O && CORE_IS_TRAP_O)) else $error("trap gated");
	AST_ACK_MASK: assert property (
		CORE_ACK_I && CORE_IRQ_O && !CORE_IS_TRAP_O |-> ##2
		(!CORE_IRQ_O || CORE_IS_TRAP_O || CORE_LEVEL_O > $past(CORE_LEVEL_O, 2))) else $error("ack no mask");
	AST_REQ_HOLD: assert property (
		CORE_IRQ_O && !CORE_IS_TRAP_O && !CORE_ACK_I && !$past(CORE_ACK_I) && !AVS_WRITE_I
		&& !$past(AVS_WRITE_I) |=> CORE_IRQ_O) else $error("request lost");
endmodule
bind pric_ctrl pric_ctrl_chk #(.N_SRC(N_SRC)) i_chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .TRAP_MATH_I(TRAP_MATH_I),
	.TRAP_CLKFAIL_I(TRAP_CLKFAIL_I), .CORE_ACK_I(CORE_ACK_I), .CORE_IRQ_O(CORE_IRQ_O),
	.CORE_VECTOR_O(CORE_VECTOR_O), .CORE_IS_TRAP_O(CORE_IS_TRAP_O), .CORE_LEVEL_O(CORE_LEVEL_O));
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module testbench import pric_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] adr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [117:0] irq = '0;
	logic [3:0] trp = 4'h0;
	logic go = 1'b0;
	logic rreq = 1'b0;
	logic [31:0] rdat;
	logic wq, ack, ret, cirq, ctrap, calt;
	logic [6:0] cvec;
	logic [3:0] clvl;
	logic [4:0] esel;
	logic [15:0] q;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	pric_ctrl i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'h3), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wq), .IRQ_I(irq), .TRAP_MATH_I(trp[0]), .TRAP_ADDR_I(trp[1]),
		.TRAP_STACK_I(trp[3]), .TRAP_CLKFAIL_I(trp[2]), .CORE_ACK_I(ack), .CORE_RET_I(ret),
		.CORE_IRQ_O(cirq), .CORE_VECTOR_O(cvec), .CORE_IS_TRAP_O(ctrap), .CORE_LEVEL_O(clvl),
		.CORE_ALT_TABLE_O(calt), .EXT_EDGE_SEL_O(esel));
	pric_core_model i_core (.clk_i(clk), .rstn_i(rstn), .irq_i(cirq), .ack_o(ack), .ret_o(ret),
		.go_i(go), .ret_req_i(rreq));
	// ====
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
		adr <= a;
		wd <= {16'h0000, d};
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wq !== 1'b0);
		q = rdat[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr16(input logic [9:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [9:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	// Request presence, trap kind and vector after the two-edge latency has passed
	task automatic req(input logic e, input logic [6:0] v);
		repeat (3) @(posedge clk);
		chk({cirq, ctrap, e ? cvec : 7'h00}, {e, e && v < 7'h08, v});
	endtask
	task automatic pulse(input int k);
		irq[k] <= 1'b1;
		@(posedge clk);
		irq[k] <= 1'b0;
	endtask
	task automatic tpulse(input int k);
		trp[k] <= 1'b1;
		@(posedge clk);
		trp[k] <= 1'b0;
	endtask
	task automatic take;
		go <= 1'b1;
		repeat (20) if (ack !== 1'b1) @(posedge clk);
		chk(ack, 1'b1);
		go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic give_back;
		rreq <= 1'b1;
		@(posedge clk);
		rreq <= 1'b0;
		@(posedge clk);
	endtask
	// ====
	// Scenarios
	task automatic s_regs;
		rdc(10'h080, 16'h4444);
		rdc(10'h0F4, 16'h0044);
		wr16(10'h084, 16'hFFFF);
		rdc(10'h084, 16'h7777);
		wr16(10'h084, 16'h4444);
		wr16(10'h05C, 16'hFFFF);
		rdc(10'h05C, 16'h003F);
		wr16(10'h05C, 16'h0000);
		wr16(10'h07C, 16'hFFFF);
		rdc(10'h07C, 16'h003F);
		pulse(117);
		req(1'b1, 7'h7D);
		wr16(10'h05C, 16'h0000);
		req(1'b0, 7'h00);
		wr16(10'h07C, 16'h0000);
		wr16(10'h000, 16'hFFFF);
		rdc(10'h000, 16'h01FF);
		wr16(10'h000, 16'h0000);
		wr16(10'h008, 16'hFFFF);
		rdc(10'h008, 16'h801E);
		wr16(10'h008, 16'h0000);
		wr16(10'h00C, 16'hFFFF);
		rdc(10'h00C, 16'h801F);
		chk({calt, esel}, 6'h3F);
		wr16(10'h00C, 16'h0000);
		wr16(10'h3F0, 16'hFFFF);
		rdc(10'h3F0, 16'h0000);
	endtask
	task automatic s_tie;
		wr16(10'h060, 16'h000C);
		wr16(10'h040, 16'h000C);
		req(1'b1, 7'h0A);
		wr16(10'h080, 16'h5444);
		req(1'b1, 7'h0B);
		chk(clvl, 4'h5);
		wr16(10'h080, 16'h0404);
		req(1'b1, 7'h0A);
		wr16(10'h080, 16'h0004);
		req(1'b0, 7'h00);
		wr16(10'h040, 16'h0000);
	endtask
	task automatic s_mask;
		wr16(10'h060, 16'h0001);
		wr16(10'h080, 16'h4447);
		wr16(10'h000, 16'h00E0);
		pulse(0);
		req(1'b0, 7'h00);
		tpulse(0);
		req(1'b1, 7'h04);
		tpulse(3);
		req(1'b1, 7'h02);
		chk(clvl, 4'hD);
		rdc(10'h008, 16'h0014);
		wr16(10'h008, 16'h0000);
		wr16(10'h000, 16'h00C0);
		req(1'b1, 7'h08);
		wr16(10'h000, 16'h0000);
		wr16(10'h040, 16'h0000);
	endtask
	task automatic s_tdis;
		wr16(10'h080, 16'h4446);
		wr16(10'h010, 16'h003C);
		pulse(0);
		req(1'b0, 7'h00);
		rdc(10'h00C, 16'h4000);
		wr16(10'h080, 16'h4447);
		req(1'b1, 7'h08);
		wr16(10'h080, 16'h4446);
		req(1'b0, 7'h00);
		tpulse(2);
		req(1'b1, 7'h01);
		wr16(10'h008, 16'h0000);
		repeat (60) @(posedge clk);
		req(1'b1, 7'h08);
		wr16(10'h040, 16'h0000);
		wr16(10'h080, 16'h4444);
	endtask
	task automatic s_ack;
		pulse(0);
		take;
		rdc(10'h000, 16'h0080);
		wr16(10'h008, 16'h8000);
		wr16(10'h080, 16'h4474);
		wr16(10'h060, 16'h0003);
		pulse(1);
		req(1'b0, 7'h00);
		wr16(10'h040, 16'h0002);
		give_back;
		req(1'b1, 7'h09);
		wr16(10'h040, 16'h0000);
		tpulse(1);
		take;
		rdc(10'h004, 16'h0008);
		wr16(10'h008, 16'h0000);
		give_back;
		rdc(10'h004, 16'h0000);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		s_regs;
		s_tie;
		s_mask;
		s_tdis;
		s_ack;
		final_report;
	end
endmodule
`default_nettype wire
